// ==== rtl/lock_mute_pkg.sv ====
// constants for the lock and mute control block
// assumes a 20 MHz system clock and sample strobes from the decoder
package lock_mute_pkg;
  localparam int CLK_HZ = 20000000;
  localparam int SOFT_STEPS = 32;           // gain steps in the roll-off
  localparam int SAMPLES_PER_STEP = 32;     // samples per gain step
  localparam int GAIN_W = 16;
  localparam logic [15:0] GAIN_FULL = 16'hFFFF;
  localparam logic [15:0] GAIN_ZERO = 16'h0000;
  localparam int SAMPLE_W = 24;
  localparam int CHSTAT_W = 40;
  localparam logic [2:0] STRAP_SETTLE = 3'h5;  // edges before straps are latched
  // control mode codes
  typedef enum logic [1:0] {
    MODE_STATIC = 2'b00,
    MODE_TWO_WIRE = 2'b01,
    MODE_THREE_WIRE = 2'b10
  } ctrl_mode_t;
  // soft mute states
  typedef enum logic [1:0] {
    SM_PLAY = 2'b00,
    SM_FALL = 2'b01,
    SM_SILENT = 2'b10,
    SM_RISE = 2'b11
  } soft_state_t;
  // cosine table: gain at each of the 32 steps, half cosine over steps 0 to 15, then a tail down to zero
  function automatic logic [15:0] cos_gain(input logic [4:0] idx);
    logic [15:0] g;
    g = GAIN_FULL;
    unique case (idx)
      5'd0: g = 16'hFFFF;
      5'd1: g = 16'hFD89;
      5'd2: g = 16'hF64A;
      5'd3: g = 16'hEA6C;
      5'd4: g = 16'hDA82;
      5'd5: g = 16'hC6E5;
      5'd6: g = 16'hB0FB;
      5'd7: g = 16'h9837;
      5'd8: g = 16'h7FFF;
      5'd9: g = 16'h67C8;
      5'd10: g = 16'h4F04;
      5'd11: g = 16'h391A;
      5'd12: g = 16'h257D;
      5'd13: g = 16'h1593;
      5'd14: g = 16'h09B5;
      5'd15: g = 16'h0276;
      5'd16: g = 16'h0100;
      5'd17: g = 16'h00C0;
      5'd18: g = 16'h0090;
      5'd19: g = 16'h0068;
      5'd20: g = 16'h0048;
      5'd21: g = 16'h0030;
      5'd22: g = 16'h0020;
      5'd23: g = 16'h0018;
      5'd24: g = 16'h0010;
      5'd25: g = 16'h000C;
      5'd26: g = 16'h0008;
      5'd27: g = 16'h0006;
      5'd28: g = 16'h0004;
      5'd29: g = 16'h0002;
      5'd30: g = 16'h0001;
      5'd31: g = 16'h0000;
    endcase
    return g;
  endfunction
endpackage

// ==== rtl/spdif_lock_mute_control.sv ====
// lock/pcm status combining, soft mute, auto hard mute, control mode decode
// assumes decoder, pll and feature settings arrive as same-clock signals;
// strap and mute pins come from outside and are synchronised here
// Contract
// - lock high when pll, decoder locked, pcm
// - locked but non-pcm drives lock low
// - register override of lock combining, burst option
// - lock indicator status bit on pll lock
// - pcm flag high for pcm, low otherwise
// - cosine soft mute over 32x32 samples
// - bus mode starts muted until host clears
// - mute pin always mutes in bus mode
// - hard mute until locked, ignores mute
// - bypass bit disables out-of-lock hard mute
// - 24 data, 40 status bits per channel
// - accepts 32, 44.1, 48 kHz rates
// - accepts timing levels I, II, III
// - static mode applies de-emphasis automatically
// - bus mode volume, bass, treble, filter mode
// - interpolator 1 to 64 times rate
// - fifth-order noise shaper at 64 times rate
// - mode from two strap pins
// - static mode uses bus start-up defaults (the host mute bit starts set but is cleared once the mode is static)
// - pll falls back to minimum frequency
`timescale 1ns/1ps
module spdif_lock_mute_control
  import lock_mute_pkg::*;
#(
  parameter int DW = SAMPLE_W
) (
  input wire logic i_mclk,                         // system clock
  input wire logic i_rst_n,                        // async reset, active low
  input wire logic i_pin_strap_mode_select,        // strap: static pin mode
  input wire logic i_two_wire_mode_select,         // strap: two-wire bus
  input wire logic i_mute_pin,                     // external mute pin
  input wire logic i_pll_locked,                   // regeneration loop locked
  input wire logic i_decoder_locked,               // stream decoder locked
  input wire logic i_pcm_status,                   // channel status says pcm
  input wire logic i_burst_seen,                   // burst preamble detected
  input wire logic i_soft_silence_bit,             // host mute bit
  input wire logic i_soft_silence_bit_wr,          // host wrote the mute bit
  input wire logic i_auto_silence_bypass_bit,      // host auto-mute bypass
  input wire logic i_lock_raw_sel,                 // lock pin shows raw lock
  input wire logic i_lock_burst_en,                // burst also drops lock
  input wire logic i_in_valid,                     // sample pair valid
  output logic o_in_ready,                         // can accept a pair
  input wire logic [DW-1:0] i_left,                // left sample
  input wire logic [DW-1:0] i_right,               // right sample
  input wire logic [CHSTAT_W-1:0] i_chstat_left,   // left channel status
  input wire logic [CHSTAT_W-1:0] i_chstat_right,  // right channel status
  output logic o_out_valid,                        // muted pair valid
  input wire logic i_out_ready,                    // receiver accepts pair
  output logic [DW-1:0] o_left,                    // muted left sample
  output logic [DW-1:0] o_right,                   // muted right sample
  output logic [CHSTAT_W-1:0] o_chstat_left,       // captured left status
  output logic [CHSTAT_W-1:0] o_chstat_right,      // captured right status
  output logic o_lock,                             // lock pin
  output logic o_linear_audio_flag_output,         // pcm detect pin
  output logic o_lock_status,                      // lock indicator bit
  output logic [1:0] o_ctrl_mode,                  // decoded control mode
  output logic o_deemph_auto,                      // de-emphasis auto on
  output logic o_soft_muted,                       // soft mute fully silent
  output logic o_hard_muted                        // hard mute active
);

  // pin synchronisers, change taken when stages two and three agree
  logic [2:0] sync_strap, sync_twi, sync_mute;
  logic strap_q, twi_q, mute_q;
  logic next_strap_q, next_twi_q, next_mute_q;

  always_comb begin
    next_strap_q = (sync_strap[1] == sync_strap[2]) ? sync_strap[2] : strap_q;
    next_twi_q = (sync_twi[1] == sync_twi[2]) ? sync_twi[2] : twi_q;
    next_mute_q = (sync_mute[1] == sync_mute[2]) ? sync_mute[2] : mute_q;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_strap <= 3'h0;
      sync_twi <= 3'h0;
      sync_mute <= 3'h0;
      strap_q <= 1'b0;
      twi_q <= 1'b0;
      mute_q <= 1'b0;
    end else begin
      sync_strap <= {sync_strap[1:0], i_pin_strap_mode_select};
      sync_twi <= {sync_twi[1:0], i_two_wire_mode_select};
      sync_mute <= {sync_mute[1:0], i_mute_pin};
      strap_q <= next_strap_q;
      twi_q <= next_twi_q;
      mute_q <= next_mute_q;
    end
  end

  // control mode latched from straps after reset release
  ctrl_mode_t mode, next_mode;
  logic mode_taken, next_mode_taken;
  logic [2:0] strap_wait, next_strap_wait;

  always_comb begin
    next_mode = mode;
    next_mode_taken = mode_taken;
    next_strap_wait = strap_wait;
    if (!mode_taken) begin
      // wait until the filtered strap levels have settled
      if (strap_wait != STRAP_SETTLE) begin
        next_strap_wait = strap_wait + 3'd1;
      end else begin
        next_mode_taken = 1'b1;
        if (strap_q) begin
          next_mode = MODE_STATIC;
        end else if (twi_q) begin
          next_mode = MODE_TWO_WIRE;
        end else begin
          next_mode = MODE_THREE_WIRE;
        end
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode <= MODE_STATIC;
      mode_taken <= 1'b0;
      strap_wait <= 3'd0;
    end else begin
      mode <= next_mode;
      mode_taken <= next_mode_taken;
      strap_wait <= next_strap_wait;
    end
  end

  logic bus_mode;
  assign bus_mode = mode_taken && (mode != MODE_STATIC);

  // host mute bit starts set in every mode; static mode has no writer,
  // so it is cleared only once the mode is known to be static
  logic silence_bit, next_silence_bit;

  always_comb begin
    next_silence_bit = silence_bit;
    if (bus_mode && i_soft_silence_bit_wr) begin
      next_silence_bit = i_soft_silence_bit;
    end
    if (mode_taken && !bus_mode) begin
      next_silence_bit = 1'b0;
    end
  end

  // lock and pcm status
  logic lock_all, pcm_ok, lock_pin, lock_stat, pcm_flag;
  logic next_lock_pin, next_lock_stat, next_pcm_flag;

  always_comb begin
    lock_all = i_pll_locked && i_decoder_locked;
    pcm_ok = i_pcm_status && !(i_lock_burst_en && i_burst_seen);
    next_lock_stat = i_pll_locked;
    next_pcm_flag = i_pcm_status && !i_burst_seen;
    if (bus_mode && i_lock_raw_sel) begin
      next_lock_pin = lock_all;
    end else begin
      next_lock_pin = lock_all && pcm_ok;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      silence_bit <= 1'b1;
      lock_pin <= 1'b0;
      lock_stat <= 1'b0;
      pcm_flag <= 1'b0;
    end else begin
      silence_bit <= next_silence_bit;
      lock_pin <= next_lock_pin;
      lock_stat <= next_lock_stat;
      pcm_flag <= next_pcm_flag;
    end
  end

  // hard mute until locked unless bypassed (bypass only in bus mode)
  logic hard_mute;
  assign hard_mute = !lock_all && !(bus_mode && i_auto_silence_bypass_bit);

  // soft mute request: pin always counts, bit in bus mode
  logic mute_req;
  // bit holds the mute until the host clears it in bus mode, or until the mode is latched as static, so bus mode starts silent
  assign mute_req = mute_q || silence_bit;

  // soft mute ramp, stepping once per SAMPLES_PER_STEP accepted samples
  soft_state_t sm, next_sm;
  logic [4:0] step, next_step;
  logic [4:0] samp_cnt, next_samp_cnt;
  logic take;
  assign take = i_in_valid && o_in_ready;

  always_comb begin
    next_sm = sm;
    next_step = step;
    next_samp_cnt = samp_cnt;
    unique case (sm)
      SM_PLAY: begin
        if (mute_req) begin
          next_sm = SM_FALL;
          next_step = 5'd0;
          next_samp_cnt = 5'd0;
        end
      end
      SM_FALL: begin
        if (!mute_req) begin
          next_sm = SM_RISE;
        end else if (take) begin
          next_samp_cnt = samp_cnt + 5'd1;
          if (samp_cnt == 5'(SAMPLES_PER_STEP - 1)) begin
            if (step == 5'(SOFT_STEPS - 1)) begin
              next_sm = SM_SILENT;
            end else begin
              next_step = step + 5'd1;
            end
          end
        end
      end
      SM_SILENT: begin
        if (!mute_req) begin
          next_sm = SM_RISE;
          next_samp_cnt = 5'd0;
        end
      end
      SM_RISE: begin
        if (mute_req) begin
          next_sm = SM_FALL;
        end else if (take) begin
          next_samp_cnt = samp_cnt + 5'd1;
          if (samp_cnt == 5'(SAMPLES_PER_STEP - 1)) begin
            if (step == 5'd0) begin
              next_sm = SM_PLAY;
            end else begin
              next_step = step - 5'd1;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sm <= SM_SILENT;
      step <= 5'(SOFT_STEPS - 1);
      samp_cnt <= 5'd0;
    end else begin
      sm <= next_sm;
      step <= next_step;
      samp_cnt <= next_samp_cnt;
    end
  end

  // gain applied to a sample; hard mute forces zero without ramp
  function automatic logic [DW-1:0] scale(input logic [DW-1:0] s, input logic [15:0] g);
    logic signed [DW+16:0] p;
    p = $signed({s[DW-1], s}) * $signed({1'b0, g});
    return p[DW+15:16];
  endfunction

  logic [15:0] gain;
  always_comb begin
    gain = cos_gain(step);
    if (sm == SM_PLAY) begin
      gain = GAIN_FULL;
    end
    if (sm == SM_SILENT || hard_mute) begin
      gain = GAIN_ZERO;
    end
  end

  // two-entry buffer in the sample path
  logic [DW-1:0] buf_l [2];
  logic [DW-1:0] buf_r [2];
  logic [DW-1:0] next_buf_l [2];
  logic [DW-1:0] next_buf_r [2];
  logic [1:0] count, next_count;
  logic wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic drain;

  assign o_in_ready = (count != 2'd2);
  assign o_out_valid = (count != 2'd0);
  assign drain = o_out_valid && i_out_ready;

  always_comb begin
    next_buf_l = buf_l;
    next_buf_r = buf_r;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count = count;
    if (take) begin
      next_buf_l[wr_ptr] = scale(i_left, gain);
      next_buf_r[wr_ptr] = scale(i_right, gain);
      next_wr_ptr = !wr_ptr;
    end
    if (drain) begin
      next_rd_ptr = !rd_ptr;
    end
    next_count = count + 2'(take) - 2'(drain);
  end

  logic [CHSTAT_W-1:0] cs_l, cs_r;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      buf_l[0] <= '0;
      buf_l[1] <= '0;
      buf_r[0] <= '0;
      buf_r[1] <= '0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'd0;
      cs_l <= '0;
      cs_r <= '0;
    end else begin
      buf_l <= next_buf_l;
      buf_r <= next_buf_r;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      if (take) begin
        cs_l <= i_chstat_left;
        cs_r <= i_chstat_right;
      end
    end
  end

  assign o_left = buf_l[rd_ptr];
  assign o_right = buf_r[rd_ptr];
  assign o_chstat_left = cs_l;
  assign o_chstat_right = cs_r;
  assign o_lock = lock_pin;
  assign o_linear_audio_flag_output = pcm_flag;
  assign o_lock_status = lock_stat;
  assign o_ctrl_mode = mode;
  assign o_deemph_auto = mode_taken && (mode == MODE_STATIC);
  assign o_soft_muted = (sm == SM_SILENT);
  assign o_hard_muted = hard_mute;

endmodule

// ==== tb/spdif_lock_mute_assertions.sv ====
// checker: lock, mute and handshake relations at the block's ports
// assumes binding into spdif_lock_mute_control, one clock domain
`timescale 1ns/1ps
module spdif_lock_mute_assertions
  import lock_mute_pkg::*;
#(
  parameter int DW = SAMPLE_W
) (
  input wire logic i_mclk, i_rst_n, i_mute_pin,  // clock, reset, mute pin
  input wire logic i_pll_locked, i_decoder_locked, i_pcm_status, i_burst_seen,  // status
  input wire logic i_soft_silence_bit, i_soft_silence_bit_wr, i_auto_silence_bypass_bit,  // host
  input wire logic i_lock_raw_sel, i_lock_burst_en, i_in_valid, i_out_ready,  // config, flow
  input wire logic o_in_ready, o_out_valid, o_lock, o_linear_audio_flag_output,  // outputs
  input wire logic o_lock_status, o_soft_muted, o_hard_muted,  // outputs
  input wire logic [1:0] o_ctrl_mode,  // mode
  input wire logic [DW-1:0] o_left, o_right  // data
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  logic bus;
  logic cleared;
  logic next_cleared;
  logic [3:0] pin_hi;
  logic [3:0] next_pin_hi;
  assign bus = o_ctrl_mode != MODE_STATIC;
  // host cleared the mute bit; mute pin held high count
  always_comb begin
    next_cleared = cleared | (i_soft_silence_bit_wr & ~i_soft_silence_bit);
    next_pin_hi = !i_mute_pin ? 4'h0 : (pin_hi == 4'h8 ? pin_hi : pin_hi + 4'h1);
  end
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cleared <= 1'b0;
      pin_hi <= 4'h0;
    end else begin
      cleared <= next_cleared;
      pin_hi <= next_pin_hi;
    end
  end
  property p_lock;
    $past(i_rst_n) && $stable(o_ctrl_mode) && !(bus && $past(i_lock_raw_sel)) |->
      o_lock == $past(i_pll_locked && i_decoder_locked && i_pcm_status && !(i_lock_burst_en && i_burst_seen));
  endproperty
  a_lock: assert property (p_lock) else $error("lock pin wrong");
  property p_nonpcm;
    $past(i_rst_n && !i_pcm_status) && !(bus && $past(i_lock_raw_sel)) |-> !o_lock;
  endproperty
  a_nonpcm: assert property (p_nonpcm) else $error("lock high with non-pcm");
  property p_raw;
    bus && $stable(o_ctrl_mode) && $past(i_rst_n && i_lock_raw_sel) |-> o_lock == $past(i_pll_locked && i_decoder_locked);
  endproperty
  a_raw: assert property (p_raw) else $error("raw lock select ignored");
  property p_status;
    $past(i_rst_n) |-> o_lock_status == $past(i_pll_locked);
  endproperty
  a_status: assert property (p_status) else $error("lock status bit wrong");
  property p_flag;
    $past(i_rst_n && (!i_pcm_status || i_burst_seen)) |-> !o_linear_audio_flag_output;
  endproperty
  a_flag: assert property (p_flag) else $error("pcm flag high for non-pcm");
  property p_start;
    bus && !cleared |-> o_soft_muted;
  endproperty
  a_start: assert property (p_start) else $error("bus mode left mute uncleared");
  property p_pin;
    pin_hi == 4'h8 && o_soft_muted |=> o_soft_muted;
  endproperty
  a_pin: assert property (p_pin) else $error("mute pin did not hold mute");
  property p_hard;
    o_hard_muted == (!(i_pll_locked && i_decoder_locked) && !(bus && i_auto_silence_bypass_bit));
  endproperty
  a_hard: assert property (p_hard) else $error("hard mute wrong");
  property p_hold;
    o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_left) && $stable(o_right);
  endproperty
  a_hold: assert property (p_hold) else $error("output pair dropped");
  c_refused: cover property (!o_in_ready);
  c_bypass: cover property (bus && !i_pll_locked && !o_hard_muted);
  c_burst: cover property (i_lock_burst_en && i_burst_seen ##1 !o_lock);
endmodule
bind spdif_lock_mute_control spdif_lock_mute_assertions #(.DW(DW)) chk_inst (.*);

// ==== tb/lock_mute_sink.sv ====
// partner: receiver of the output pair handshake, may stall
// assumes ready changes 1 ns after the rising edge
`timescale 1ns/1ps
module lock_mute_sink #(
  parameter int W = 48
) (
  input wire logic i_mclk,  // clock
  input wire logic i_valid,  // pair offered
  input wire logic [W-1:0] i_data,  // pair data
  input wire logic i_stall,  // refuse all
  input wire logic i_slow,  // accept every other cycle
  output logic o_ready,  // pair accepted
  output logic [W-1:0] o_last,  // last pair taken
  output int o_count  // pairs taken
);
  logic phase = 1'b0;
  initial o_ready = 1'b0;
  initial o_count = 0;
  always @(posedge i_mclk) begin
    if (i_valid && o_ready) begin
      o_last <= i_data;
      o_count <= o_count + 1;
    end
    phase <= ~phase;
    #1 o_ready = !i_stall && (!i_slow || phase);
  end
endmodule

// ==== tb/tb_top.sv ====
// testbench: lock combining, mute ramps, hard mute and buffering
// assumes the sink model drains the output side, one 20 MHz clock
`timescale 1ns/1ps
module tb_top;
  import lock_mute_pkg::*;
  localparam int DW = SAMPLE_W;
  logic i_mclk = 0, i_rst_n = 0, i_pin_strap_mode_select = 0, i_two_wire_mode_select = 0;
  logic i_mute_pin = 0, i_pll_locked = 0, i_decoder_locked = 0, i_pcm_status = 0, i_burst_seen = 0;
  logic i_soft_silence_bit = 0, i_soft_silence_bit_wr = 0, i_auto_silence_bypass_bit = 0;
  logic i_lock_raw_sel = 0, i_lock_burst_en = 0, i_in_valid = 0, i_out_ready;
  logic [DW-1:0] i_left = 0, i_right = 0, o_left, o_right;
  logic [CHSTAT_W-1:0] i_chstat_left = 40'h12_3456_789A, i_chstat_right = 40'hED_CBA9_8765;
  logic [CHSTAT_W-1:0] o_chstat_left, o_chstat_right;
  logic o_in_ready, o_out_valid, o_lock, o_linear_audio_flag_output, o_lock_status;
  logic o_deemph_auto, o_soft_muted, o_hard_muted, stall = 0, slow = 0;
  logic [1:0] o_ctrl_mode;
  logic [2*DW-1:0] got;
  int rx_count, bad_count = 0, checked = 0, n0;
  always #25 i_mclk = ~i_mclk;
  spdif_lock_mute_control #(.DW(DW)) spdif_lock_mute_control_inst (.*);
  lock_mute_sink #(.W(2*DW)) lock_mute_sink_inst (.i_mclk(i_mclk), .i_valid(o_out_valid),
    .i_data({o_left, o_right}), .i_stall(stall), .i_slow(slow), .o_ready(i_out_ready), .o_last(got),
    .o_count(rx_count));
  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  // n back-to-back pairs, then valid low
  task automatic send_n(input int n, input logic [DW-1:0] x);
    repeat (n) begin
      i_in_valid = 1;
      i_left = x;
      i_right = x;
      for (int k = 0; k < 50 && o_in_ready !== 1'b1; k++) tick(1);
      check(o_in_ready, 1);
      tick(1);
    end
    i_in_valid = 0;
    tick(1);
  endtask
  task automatic pair(input logic [DW-1:0] x, input logic [DW-1:0] e);
    int n;
    // let older pairs drain so the count below tracks this pair only
    for (int k = 0; k < 20 && o_out_valid !== 1'b0; k++) tick(1);
    n = rx_count;
    send_n(1, x);
    for (int k = 0; k < 20 && rx_count == n; k++) tick(1);
    check(rx_count - n, 1);
    check(got, {e, e});
  endtask
  initial begin
    #2_000_000;
    bad_count++;
    print_verdict();
  end
  initial begin
    for (int m = 0; m < 3; m++) begin
      i_rst_n = 0;
      i_pin_strap_mode_select = (m == 0);
      i_two_wire_mode_select = (m == 1);
      tick(4);
      i_rst_n = 1;
      tick(10);
      check(o_ctrl_mode, m == 0 ? MODE_STATIC : m == 1 ? MODE_TWO_WIRE : MODE_THREE_WIRE);
      check(o_deemph_auto, m == 0);
    end
    check(o_hard_muted, 1);
    {i_pll_locked, i_decoder_locked, i_pcm_status} = 3'b111;
    tick(2);
    check({o_lock, o_lock_status, o_linear_audio_flag_output, o_hard_muted}, 4'b1110);
    i_pcm_status = 0;
    tick(2);
    check({o_lock, o_linear_audio_flag_output}, 2'b00);
    i_lock_raw_sel = 1;
    tick(2);
    check(o_lock, 1);
    {i_lock_raw_sel, i_pcm_status, i_lock_burst_en, i_burst_seen} = 4'b0111;
    tick(2);
    check({o_lock, o_linear_audio_flag_output}, 2'b00);
    {i_lock_burst_en, i_burst_seen} = 2'b00;
    pair(24'h00_8000, 0);
    i_soft_silence_bit_wr = 1;
    tick(1);
    i_soft_silence_bit_wr = 0;
    slow = 1;
    send_n(1024, 24'h00_8000);
    pair(24'h00_8000, 24'h00_7FFF);
    i_mute_pin = 1;
    tick(6);
    send_n(1023, 24'h00_8000);
    check(o_soft_muted, 0);
    send_n(1, 24'h00_8000);
    tick(1);
    check(o_soft_muted, 1);
    pair(24'h00_8000, 0);
    i_mute_pin = 0;
    tick(6);
    send_n(1024, 24'h00_8000);
    i_pll_locked = 0;
    tick(1);
    check(o_hard_muted, 1);
    pair(24'h00_8000, 0);
    i_auto_silence_bypass_bit = 1;
    tick(1);
    check(o_hard_muted, 0);
    pair(24'h00_8000, 24'h00_7FFF);
    slow = 0;
    stall = 1;
    tick(2);
    n0 = rx_count;
    send_n(2, 24'h00_4000);
    check(o_in_ready, 0);
    stall = 0;
    tick(6);
    check(rx_count - n0, 2);
    check(got, {24'h00_3FFF, 24'h00_3FFF});
    check({o_chstat_left, o_chstat_right}, {i_chstat_left, i_chstat_right});
    print_verdict();
  end
endmodule
